// ==== hdl/lp_coproc_pkg.sv ====
package lp_coproc_pkg;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned GPR_W = 16;
   localparam int unsigned GPR_NUM = 4;
   localparam int unsigned STAGE_W = 8;
   localparam int unsigned MEM_AW = 11;
   localparam logic [31:0] SLOW_MEM_BASE = 32'h5000_0000;
   localparam logic [31:0] SLOW_MEM_LAST = 32'h5000_1fff;
   localparam logic [31:0] PERIOD_RESET = 32'h0000_0001;

   localparam int unsigned OPC_MSB = 31;
   localparam int unsigned OPC_LSB = 28;
   localparam int unsigned KIND_MSB = 27;
   localparam int unsigned KIND_LSB = 26;
   localparam int unsigned SEL_MSB = 24;
   localparam int unsigned SEL_LSB = 21;
   localparam int unsigned IMM_MSB = 19;
   localparam int unsigned IMM_LSB = 4;
   localparam int unsigned SIMM_MSB = 11;
   localparam int unsigned SIMM_LSB = 4;
   localparam int unsigned DST_MSB = 1;
   localparam int unsigned DST_LSB = 0;
   localparam int unsigned SRCA_MSB = 3;
   localparam int unsigned SRCA_LSB = 2;
   localparam int unsigned SRCB_MSB = 5;
   localparam int unsigned SRCB_LSB = 4;

   localparam logic [3:0] OPC_ALU = 4'h7;
   localparam logic [3:0] OPC_HALT = 4'hb;

   localparam logic [1:0] KIND_REG = 2'h0;
   localparam logic [1:0] KIND_IMM = 2'h1;
   localparam logic [1:0] KIND_STAGE = 2'h2;

   localparam logic [3:0] ALU_ADD = 4'h0;
   localparam logic [3:0] ALU_SUB = 4'h1;
   localparam logic [3:0] ALU_AND = 4'h2;
   localparam logic [3:0] ALU_OR = 4'h3;
   localparam logic [3:0] ALU_MOVE = 4'h4;
   localparam logic [3:0] ALU_LSH = 4'h5;
   localparam logic [3:0] ALU_RSH = 4'h6;
   localparam logic [3:0] STAGE_INC = 4'h0;
   localparam logic [3:0] STAGE_DEC = 4'h1;
   localparam logic [3:0] STAGE_RST = 4'h2;

   localparam logic COPROC_RISCV = 1'b0;
   localparam logic COPROC_FSM = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_COUNT = 3'b001,
      ST_FETCH = 3'b010,
      ST_WAIT = 3'b011,
      ST_EXEC = 3'b100,
      ST_RISCV = 3'b101
   } seq_state_t;
endpackage : lp_coproc_pkg

// ==== hdl/alu_if.sv ====
`timescale 1ns/1ps
interface alu_if;
   logic [1:0] kind;
   logic [3:0] op;
   logic [15:0] a;
   logic [15:0] b;
   logic [7:0] stage;
   logic [7:0] simm;
   logic [15:0] res;
   logic [7:0] stage_res;
   logic zero;
   logic ovf;
   logic ovf_upd;
   logic gpr_wr;
   logic stage_wr;
   modport ctrl (output kind, op, a, b, stage, simm,
                 input res, stage_res, zero, ovf, ovf_upd, gpr_wr, stage_wr);
   modport unit (input kind, op, a, b, stage, simm,
                 output res, stage_res, zero, ovf, ovf_upd, gpr_wr, stage_wr);
endinterface : alu_if

// ==== hdl/fsm_alu.sv ====
`timescale 1ns/1ps
module fsm_alu (
   alu_if.unit alu
);
   import lp_coproc_pkg::*;

   always_comb begin
      alu.res = '0;
      alu.stage_res = alu.stage;
      alu.ovf = 1'b0;
      alu.ovf_upd = 1'b0;
      alu.gpr_wr = 1'b0;
      alu.stage_wr = 1'b0;
      if (alu.kind == KIND_REG || alu.kind == KIND_IMM) begin
         alu.gpr_wr = 1'b1;
         case (alu.op)
            ALU_ADD: begin
               alu.res = alu.a + alu.b;
               alu.ovf_upd = 1'b1;
               alu.ovf = (alu.a[15] == alu.b[15]) && (alu.res[15] != alu.a[15]);
            end
            ALU_SUB: begin
               alu.res = alu.a - alu.b;
               alu.ovf_upd = 1'b1;
               alu.ovf = (alu.a[15] != alu.b[15]) && (alu.res[15] != alu.a[15]);
            end
            ALU_AND: alu.res = alu.a & alu.b;
            ALU_OR: alu.res = alu.a | alu.b;
            ALU_MOVE: alu.res = (alu.kind == KIND_IMM) ? alu.b : alu.a;
            ALU_LSH: alu.res = alu.a << alu.b;
            ALU_RSH: alu.res = alu.a >> alu.b;
            default: alu.gpr_wr = 1'b0;
         endcase
      end else if (alu.kind == KIND_STAGE) begin
         alu.stage_wr = 1'b1;
         case (alu.op)
            STAGE_INC: alu.stage_res = alu.stage + alu.simm;
            STAGE_DEC: alu.stage_res = alu.stage - alu.simm;
            STAGE_RST: alu.stage_res = '0;
            default: alu.stage_wr = 1'b0;
         endcase
      end
      alu.zero = alu.stage_wr ? (alu.stage_res == '0) : (alu.res == '0);
   end
endmodule : fsm_alu

// ==== hdl/low_power_fsm_coprocessor.sv ====
// Summary of operation
// - Never run the state-machine core and the RISC-V core together.
// - Wake timer counts programmed cycles only while software or pin enable is set.
// - Each expiry enters monitor mode, wakes the core, then returns to sleep.
// - On expiry the core starts running its program from slow memory.
// - When the core halts the wake timer restarts counting.
// - A halted core stays idle until the next wakeup.
// - The halt instruction halts the state-machine core.
// - Disabling the timer ends monitor mode; pin disable also uses pin clear.
// - The core runs from the 8 MHz fast low-power clock.
// - Four 16-bit general-purpose registers R0 to R3.
// - Separate 8-bit stage counter changed by the ALU.
// - Instructions are 32 bits wide; program flow uses 32-bit addressing.
// - Program and data live in 8 KB slow memory at 0x5000_0000 to 0x5000_1fff.
// - Opcode 7 marks ALU instructions; bits 27:21 pick the operation.
// - Bits 27:26 zero: two source registers into a destination register.
// - Select 0 add, 1 subtract, 2 AND, 3 OR on register operands.
// - Bits 27:26 one: source register with signed immediate from bits 19:4.
// - Add and subtract update the overflow flag.
// - Every ALU operation updates the zero flag.
`timescale 1ns/1ps
module low_power_fsm_coprocessor (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic coprocessor_select_i,
   input wire logic [31:0] wake_timer_period_i,
   input wire logic sw_timer_enable_i,
   input wire logic pin_timer_enable_i,
   input wire logic pin_timer_clear_i,
   input wire logic riscv_done_flag_i,
   input wire logic [lp_coproc_pkg::WORD_W-1:0] mem_rdata_i,
   input wire logic mem_valid_i,
   input wire logic [1:0] gpr_sel_i,
   output logic mem_req_o,
   output logic [31:0] mem_addr_o,
   output logic monitor_mode_o,
   output logic fsm_running_o,
   output logic riscv_run_o,
   output logic halted_o,
   output logic timer_expired_o,
   output logic [lp_coproc_pkg::GPR_W-1:0] gpr_data_o,
   output logic [lp_coproc_pkg::STAGE_W-1:0] stage_cnt_o,
   output logic zero_flag_o,
   output logic overflow_flag_o,
   output logic [31:0] pc_o
);
   import lp_coproc_pkg::*;

   seq_state_t state_r;
   seq_state_t state_nxt;
   logic [31:0] timer_cnt_r;
   logic [31:0] pc_r;
   logic [WORD_W-1:0] instr_r;
   logic [GPR_W-1:0] gpr_r [GPR_NUM];
   logic [STAGE_W-1:0] stage_r;
   logic zero_r;
   logic ovf_r;
   logic timer_en;
   logic expire;
   logic exec_halt;
   logic exec_alu;
   logic [1:0] dst_idx;
   logic [1:0] srca_idx;
   logic [1:0] srcb_idx;
   logic [1:0] kind;

   alu_if alu_bus ();

   fsm_alu i_fsm_alu (
      .alu(alu_bus.unit)
   );

   // Pin clear forces the enable low even while the pin enable still reads set
   assign timer_en = (sw_timer_enable_i | pin_timer_enable_i) & ~pin_timer_clear_i;
   assign expire = (timer_cnt_r + 32'h1 >= wake_timer_period_i);
   assign kind = instr_r[KIND_MSB:KIND_LSB];
   assign dst_idx = instr_r[DST_MSB:DST_LSB];
   assign srca_idx = instr_r[SRCA_MSB:SRCA_LSB];
   assign srcb_idx = instr_r[SRCB_MSB:SRCB_LSB];
   assign exec_alu = (state_r == ST_EXEC) && (instr_r[OPC_MSB:OPC_LSB] == OPC_ALU);
   assign exec_halt = (state_r == ST_EXEC) && (instr_r[OPC_MSB:OPC_LSB] == OPC_HALT);

   always_comb begin
      alu_bus.kind = kind;
      alu_bus.op = instr_r[SEL_MSB:SEL_LSB];
      alu_bus.a = gpr_r[srca_idx];
      alu_bus.stage = stage_r;
      alu_bus.simm = instr_r[SIMM_MSB:SIMM_LSB];
      if (kind == KIND_IMM) begin
         alu_bus.b = instr_r[IMM_MSB:IMM_LSB];
      end else begin
         alu_bus.b = gpr_r[srcb_idx];
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (timer_en) begin
               state_nxt = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (expire) begin
               // Only the selected core is started, never both
               if (coprocessor_select_i == COPROC_FSM) begin
                  state_nxt = ST_FETCH;
               end else begin
                  state_nxt = ST_RISCV;
               end
            end
         end
         ST_FETCH: state_nxt = ST_WAIT;
         ST_WAIT: begin
            if (mem_valid_i) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (exec_halt) begin
               state_nxt = ST_COUNT;
            end else begin
               state_nxt = ST_FETCH;
            end
         end
         ST_RISCV: begin
            if (riscv_done_flag_i) begin
               state_nxt = ST_COUNT;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (!timer_en) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         timer_cnt_r <= '0;
      end else if (state_r == ST_COUNT && timer_en && !expire) begin
         timer_cnt_r <= timer_cnt_r + 32'h1;
      end else begin
         // Cleared whenever not counting, so each halt starts a fresh period
         timer_cnt_r <= '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pc_r <= '0;
      end else if (state_r == ST_COUNT) begin
         pc_r <= '0;
      end else if (state_r == ST_EXEC && !exec_halt) begin
         // Word index wraps inside the 8 KB window
         pc_r <= {21'h0, pc_r[MEM_AW-1:0] + 11'h1};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         instr_r <= '0;
      end else if (state_r == ST_WAIT && mem_valid_i) begin
         instr_r <= mem_rdata_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mem_req_o <= 1'b0;
         mem_addr_o <= SLOW_MEM_BASE;
      end else begin
         mem_req_o <= (state_nxt == ST_FETCH);
         if (state_nxt == ST_FETCH) begin
            mem_addr_o <= SLOW_MEM_BASE + {19'h0, pc_nxt_word(), 2'b00};
         end
      end
   end

   function automatic logic [MEM_AW-1:0] pc_nxt_word();
      logic [MEM_AW-1:0] w;
      w = pc_r[MEM_AW-1:0];
      if (state_r == ST_COUNT) begin
         w = '0;
      end else if (state_r == ST_EXEC) begin
         w = pc_r[MEM_AW-1:0] + 11'h1;
      end
      return w;
   endfunction : pc_nxt_word

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < GPR_NUM; i++) begin
            gpr_r[i] <= '0;
         end
      end else if (exec_alu && alu_bus.gpr_wr) begin
         gpr_r[dst_idx] <= alu_bus.res;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         stage_r <= '0;
      end else if (exec_alu && alu_bus.stage_wr) begin
         stage_r <= alu_bus.stage_res;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         zero_r <= 1'b0;
         ovf_r <= 1'b0;
      end else if (exec_alu && (alu_bus.gpr_wr || alu_bus.stage_wr)) begin
         zero_r <= alu_bus.zero;
         if (alu_bus.ovf_upd) begin
            ovf_r <= alu_bus.ovf;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         monitor_mode_o <= 1'b0;
         fsm_running_o <= 1'b0;
         riscv_run_o <= 1'b0;
         halted_o <= 1'b1;
         timer_expired_o <= 1'b0;
      end else begin
         // Monitor mode spans the wake, dropped on halt or timer disable
         monitor_mode_o <= (state_nxt != ST_IDLE) && (state_nxt != ST_COUNT);
         fsm_running_o <= (state_nxt == ST_FETCH) || (state_nxt == ST_WAIT)
                          || (state_nxt == ST_EXEC);
         riscv_run_o <= (state_nxt == ST_RISCV);
         halted_o <= (state_nxt == ST_IDLE) || (state_nxt == ST_COUNT);
         timer_expired_o <= (state_r == ST_COUNT) && expire && timer_en;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         gpr_data_o <= '0;
         stage_cnt_o <= '0;
         zero_flag_o <= 1'b0;
         overflow_flag_o <= 1'b0;
         pc_o <= '0;
      end else begin
         gpr_data_o <= gpr_r[gpr_sel_i];
         stage_cnt_o <= stage_r;
         zero_flag_o <= zero_r;
         overflow_flag_o <= ovf_r;
         pc_o <= pc_r;
      end
   end
endmodule : low_power_fsm_coprocessor

// ==== tb/coproc_assertions.sv ====
`timescale 1ns/1ps
module coproc_assertions
   import lp_coproc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic sw_timer_enable_i,
   input wire logic pin_timer_enable_i,
   input wire logic pin_timer_clear_i,
   input wire logic mem_req_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic monitor_mode_o,
   input wire logic fsm_running_o,
   input wire logic riscv_run_o,
   input wire logic halted_o,
   input wire logic timer_expired_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   chk_one_core: assert property (!(fsm_running_o && riscv_run_o))
      else $error("both cores running");
   chk_halt_idle: assert property (halted_o |-> !fsm_running_o && !riscv_run_o)
      else $error("halted core still running");
   chk_fetch_range: assert property (mem_req_o |-> mem_addr_o >= SLOW_MEM_BASE &&
      mem_addr_o <= SLOW_MEM_LAST && mem_addr_o[1:0] == 2'h0) else $error("fetch address bad");
   chk_fetch_pulse: assert property (mem_req_o |=> !mem_req_o)
      else $error("fetch request longer than one cycle");
   chk_clear_idle: assert property (pin_timer_clear_i |-> ##2 !monitor_mode_o && halted_o)
      else $error("pin clear did not stop the core");
   chk_enables_off: assert property (!sw_timer_enable_i && !pin_timer_enable_i |->
      ##2 !monitor_mode_o && !fsm_running_o && !riscv_run_o) else $error("runs while disabled");
   chk_expiry_mon: assert property (timer_expired_o |-> monitor_mode_o)
      else $error("expiry without monitor mode");
   chk_run_fetch: assert property ($rose(fsm_running_o) |-> ##[0:1] mem_req_o)
      else $error("core woke without fetching");
   cov_fsm_run: cover property ($rose(fsm_running_o));
   cov_riscv_run: cover property ($rose(riscv_run_o));
   cov_halt: cover property ($rose(halted_o));
endmodule : coproc_assertions

bind low_power_fsm_coprocessor coproc_assertions i_coproc_assertions (.mclk_i(mclk_i),
   .rst_n_i(rst_n_i), .sw_timer_enable_i(sw_timer_enable_i),
   .pin_timer_enable_i(pin_timer_enable_i), .pin_timer_clear_i(pin_timer_clear_i),
   .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .monitor_mode_o(monitor_mode_o),
   .fsm_running_o(fsm_running_o), .riscv_run_o(riscv_run_o), .halted_o(halted_o),
   .timer_expired_o(timer_expired_o));

// ==== tb/slow_mem_model.sv ====
`timescale 1ns/1ps
module slow_mem_model (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic mem_req_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic [7:0] lat_i,
   output logic [31:0] mem_rdata_o,
   output logic mem_valid_o
);
   logic [31:0] words [0:2047];
   logic [10:0] idx_r;
   logic [7:0] cnt_r;
   logic pend_r;
   // Word index inside the 8 KB window; data bus shows junk when idle
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pend_r <= 1'b0;
         mem_valid_o <= 1'b0;
         mem_rdata_o <= 32'h0;
      end else if (mem_req_i) begin
         idx_r <= mem_addr_i[12:2];
         cnt_r <= lat_i;
         pend_r <= 1'b1;
         mem_valid_o <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
      end else if (pend_r && cnt_r == 8'h0) begin
         pend_r <= 1'b0;
         mem_valid_o <= 1'b1;
         mem_rdata_o <= words[idx_r];
      end else begin
         mem_valid_o <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         if (pend_r) begin
            cnt_r <= cnt_r - 8'h1;
         end
      end
   end
endmodule : slow_mem_model

// ==== tb/tb_low_power_fsm_coprocessor.sv ====
`timescale 1ns/1ps
module tb_low_power_fsm_coprocessor;
   import lp_coproc_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sel = 1'b0, sw_en = 1'b0, pin_en = 1'b0, pin_clr = 1'b0, done = 1'b0;
   logic [31:0] period = 32'h4;
   logic [1:0] gsel = 2'h0;
   logic [7:0] lat = 8'h0;
   logic [31:0] rdata, addr, pc;
   logic valid, req, mon, run, rv, halt, expd, zf, of;
   logic [15:0] gdata;
   logic [7:0] stage;
   int fail_count = 0;
   int checks_done = 0;
   always #10 mclk_i = ~mclk_i;
   low_power_fsm_coprocessor i_low_power_fsm_coprocessor (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .coprocessor_select_i(sel), .wake_timer_period_i(period), .sw_timer_enable_i(sw_en),
      .pin_timer_enable_i(pin_en), .pin_timer_clear_i(pin_clr), .riscv_done_flag_i(done),
      .mem_rdata_i(rdata), .mem_valid_i(valid), .gpr_sel_i(gsel), .mem_req_o(req),
      .mem_addr_o(addr), .monitor_mode_o(mon), .fsm_running_o(run), .riscv_run_o(rv),
      .halted_o(halt), .timer_expired_o(expd), .gpr_data_o(gdata), .stage_cnt_o(stage),
      .zero_flag_o(zf), .overflow_flag_o(of), .pc_o(pc));
   slow_mem_model i_slow_mem_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mem_req_i(req),
      .mem_addr_i(addr), .lat_i(lat), .mem_rdata_o(rdata), .mem_valid_o(valid));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick
   // Bounded wait: 0 halted, 1 fsm run, 2 riscv run, 3 fetch; returns cycles waited
   task automatic wait_hi(input int w, output int n);
      n = 0;
      while ((w == 0 ? halt : w == 1 ? run : w == 2 ? rv : req) !== 1'b1) begin
         tick(1);
         n++;
         if (n > 3000) begin
            fail_count++;
            $display("ERROR t=%0t wait %0d timed out", $time, w);
            summarize();
         end
      end
   endtask : wait_hi
   function automatic logic [31:0] alu(logic [1:0] k, logic [3:0] s, logic [15:0] v,
                                       logic [1:0] a, logic [1:0] d);
      return {OPC_ALU, k, 1'b0, s, 1'b0, v, a, d};
   endfunction : alu
   task automatic t_alu_program;
      int n;
      logic [15:0] exp [4];
      exp = '{16'h0, 16'h7fff, 16'h8000, 16'h1};
      i_slow_mem_model.words[0] = alu(KIND_IMM, ALU_MOVE, 16'h7fff, 2'h0, 2'h1);
      i_slow_mem_model.words[1] = alu(KIND_IMM, ALU_MOVE, 16'h0001, 2'h0, 2'h2);
      i_slow_mem_model.words[2] = alu(KIND_STAGE, STAGE_INC, 16'h0003, 2'h0, 2'h0);
      i_slow_mem_model.words[3] = alu(KIND_REG, ALU_OR, 16'h0002, 2'h1, 2'h3);
      i_slow_mem_model.words[4] = alu(KIND_REG, ALU_AND, 16'h0002, 2'h3, 2'h3);
      i_slow_mem_model.words[5] = alu(KIND_REG, ALU_SUB, 16'h0003, 2'h3, 2'h0);
      i_slow_mem_model.words[6] = alu(KIND_REG, ALU_ADD, 16'h0002, 2'h1, 2'h2);
      i_slow_mem_model.words[7] = alu(KIND_REG, ALU_AND, 16'h0000, 2'h0, 2'h0);
      i_slow_mem_model.words[8] = {OPC_HALT, 28'h0};
      @(posedge mclk_i);
      sel <= COPROC_FSM;
      lat <= 8'h3;
      sw_en <= 1'b1;
      tick(1);
      wait_hi(3, n);
      check(32'(n >= 3 && n <= 8), 32'h1);
      check(addr, SLOW_MEM_BASE);
      check(32'(expd), 32'h1);
      tick(1);
      wait_hi(3, n);
      check(addr, SLOW_MEM_BASE + 32'h4);
      tick(1);
      check(pc, 32'h1);
      wait_hi(0, n);
      @(posedge mclk_i);
      sw_en <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         @(posedge mclk_i);
         gsel <= 2'(r);
         tick(2);
         check(32'(gdata), 32'(exp[r]));
      end
      check(32'(stage), 32'h3);
      check(32'(of), 32'h1);
      check(32'(zf), 32'h1);
      $display("test alu_program done");
   endtask : t_alu_program
   task automatic t_pin_abort;
      int n;
      @(posedge mclk_i);
      lat <= 8'h1e;
      period <= 32'h6;
      pin_en <= 1'b1;
      tick(1);
      wait_hi(1, n);
      check(32'(mon), 32'h1);
      @(posedge mclk_i);
      pin_en <= 1'b0;
      pin_clr <= 1'b1;
      tick(2);
      check(32'({mon, run, halt}), 32'h1);
      @(posedge mclk_i);
      pin_clr <= 1'b0;
      n = 0;
      repeat (40) begin
         tick(1);
         n += int'(req);
      end
      check(32'(n), 32'h0);
      $display("test pin_abort done");
   endtask : t_pin_abort
   task automatic t_riscv;
      int n;
      @(posedge mclk_i);
      sel <= COPROC_RISCV;
      period <= 32'h4;
      sw_en <= 1'b1;
      tick(1);
      wait_hi(2, n);
      tick(5);
      check(32'({rv, run, mon}), 32'h5);
      @(posedge mclk_i);
      done <= 1'b1;
      @(posedge mclk_i);
      done <= 1'b0;
      tick(2);
      check(32'({rv, halt}), 32'h1);
      wait_hi(2, n);
      check(32'(n >= 1 && n <= 8), 32'h1);
      @(posedge mclk_i);
      sw_en <= 1'b0;
      tick(3);
      check(32'(halt), 32'h1);
      $display("test riscv done");
   endtask : t_riscv
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      tick(1);
      check(32'({halt, mon, run, rv}), 32'h8);
      check(addr, SLOW_MEM_BASE);
      t_alu_program();
      t_pin_abort();
      t_riscv();
      summarize();
   end
endmodule : tb_low_power_fsm_coprocessor
